/* verilog/pcfg_pkg.sv */
package pcfg_pkg;
   // register indexes on the management port
   localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_PHY_STATUS_SUMMARY = 5'h10;
   localparam logic [4:0] ADDR_LED_DIRECT_CONTROL = 5'h18;
   localparam logic [4:0] ADDR_PHY_CONTROL = 5'h19;
   localparam logic [4:0] ADDR_DIAG_CONTROL_ONE = 5'h1B;

   // basic_mode_control fields
   localparam int BMC_LOOPBACK = 14;
   localparam int BMC_SPEED100 = 13;
   localparam int BMC_AUTONEG_EN = 12;
   localparam int BMC_ISOLATE = 10;
   localparam int BMC_FULL_DUPLEX = 8;
   localparam logic [15:0] BMC_WRITE_MASK = 16'h7500;
   localparam logic [15:0] BMC_RESET = 16'h3000;

   // phy_status_summary fields
   localparam int PSS_LINK = 0;
   localparam int PSS_SPEED10 = 1;
   localparam int PSS_FULL_DUPLEX = 2;
   localparam int PSS_LOOPBACK = 3;

   // phy_control fields
   localparam int PHC_ADDR_LSB = 0;
   localparam int PHC_ADDR_MSB = 4;
   localparam int PHC_INDICATOR_MODE = 5;
   localparam int PHC_SELFTEST_START = 8;
   localparam int PHC_SELFTEST_PASS = 10;
   localparam int PHC_PRBS_LENGTH = 11;
   localparam logic [15:0] PHC_WRITE_MASK = 16'h093F;
   localparam logic [4:0] PHC_ADDR_DEFAULT = 5'h01;

   // led_direct_control fields
   localparam int LDC_SPEED_OVERRIDE = 4;
   localparam int LDC_LINK_OVERRIDE = 3;
   localparam int LDC_SPEED_VALUE = 1;
   localparam int LDC_LINK_VALUE = 0;
   localparam logic [15:0] LDC_WRITE_MASK = 16'h001B;

   // diag_control_one fields
   localparam int DC1_ERR_LSB = 8;
   localparam int DC1_ERR_MSB = 15;
   localparam int DC1_CONTINUOUS = 5;
   localparam logic [15:0] DC1_WRITE_MASK = 16'h0020;

   // timing counts in clock cycles, except LINK_PULSES_NEEDED, which counts link pulses, and PRBS_FILL, which counts received bits
   localparam int STRAP_SETTLE_CYCLES = 3;
   localparam int LINK_PULSES_NEEDED = 7;
   localparam int COL_DELAY_BITS = 7;
   localparam int PRBS_FILL = 15;
   localparam int SELFTEST_PKT_CYCLES = 1500;
   localparam int SELFTEST_GAP_CYCLES = 96;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pcfg_mgmt_req_t;

   typedef struct packed {
      logic rx_dv;
      logic rx_er;
      logic [3:0] rxd;
   } pcfg_mii_rx_t;

   typedef struct packed {
      logic tx_en;
      logic [3:0] txd;
   } pcfg_mii_tx_t;
endpackage

/* verilog/pcfg_prbs.sv */
// one lfsr, used either free running (generator) or fed by received bits (checker)
module pcfg_prbs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic step,
   input wire logic long_sel,
   input wire logic feed_ext,
   input wire logic ext_bit,
   output logic predict
);
   logic [14:0] sr_reg;
   logic [14:0] sr_next;
   logic fb;

   always_comb begin
      fb = long_sel ? (sr_reg[14] ^ sr_reg[13]) : (sr_reg[8] ^ sr_reg[4]);
      predict = fb;
      sr_next = {sr_reg[13:0], feed_ext ? ext_bit : fb};
   end

   // all-ones seed keeps the generator out of the stuck zero state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sr_reg <= 15'h7FFF;
      end else if (ce && step) begin
         sr_reg <= sr_next;
      end
   end
endmodule

/* verilog/pcfg_top.sv */
module pcfg_top #(
   parameter int BLINK_CYCLES = 2000000
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire pcfg_pkg::pcfg_mgmt_req_t mgmt_req,
   output logic mgmt_ack,
   output logic [15:0] mgmt_rdata,
   input wire logic [4:0] address_strap,
   input wire logic indicator_mode_select,
   input wire pcfg_pkg::pcfg_mii_tx_t mii_tx,
   output pcfg_pkg::pcfg_mii_rx_t mii_rx,
   output logic mii_crs,
   output logic mii_col,
   output logic mii_clk_o,
   output logic mii_oe,
   input wire logic an_speed100,
   input wire logic an_full_duplex,
   input wire logic media_signal_detect,
   input wire logic media_link_pulse,
   input wire logic media_link_fail,
   input wire logic media_valid_packet,
   input wire pcfg_pkg::pcfg_mii_rx_t media_rx,
   output pcfg_pkg::pcfg_mii_tx_t media_tx,
   output logic media_idle,
   input wire logic link_indicator_i,
   output logic link_indicator_o,
   output logic link_indicator_oe,
   input wire logic rate_indicator_i,
   output logic rate_indicator_o,
   output logic rate_indicator_oe
);
   localparam int BW = $clog2(BLINK_CYCLES + 1);

   // pin synchronisers: stage one is read only by stage two
   logic [7:0] strap_s1_reg;
   logic [7:0] strap_s2_reg;
   pcfg_pkg::pcfg_mii_tx_t tx_s1_reg;
   pcfg_pkg::pcfg_mii_tx_t tx_s2_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_s1_reg <= 8'h00;
         strap_s2_reg <= 8'h00;
         tx_s1_reg <= '0;
         tx_s2_reg <= '0;
      end else if (ce) begin
         strap_s1_reg <= {rate_indicator_i, link_indicator_i, indicator_mode_select,
            address_strap};
         strap_s2_reg <= strap_s1_reg;
         tx_s1_reg <= mii_tx;
         tx_s2_reg <= tx_s1_reg;
      end
   end

   // strap capture a few cycles after reset release, once synchronisers hold pin levels
   logic [1:0] settle_reg;
   logic strapped_reg;
   logic strap_iso_reg;
   logic link_pol_reg;
   logic rate_pol_reg;
   logic capture;
   assign capture = ce && !strapped_reg && settle_reg == 2'(pcfg_pkg::STRAP_SETTLE_CYCLES - 1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         settle_reg <= 2'h0;
         strapped_reg <= 1'b0;
         strap_iso_reg <= 1'b0;
         link_pol_reg <= 1'b0;
         rate_pol_reg <= 1'b0;
      end else if (ce && !strapped_reg) begin
         settle_reg <= settle_reg + 2'h1;
         if (capture) begin
            strapped_reg <= 1'b1;
            strap_iso_reg <= (strap_s2_reg[4:0] == 5'h00);
            link_pol_reg <= strap_s2_reg[6];
            rate_pol_reg <= strap_s2_reg[7];
         end
      end
   end

   // registers
   logic [15:0] bmc_reg;
   logic [15:0] phc_reg;
   logic [15:0] ldc_reg;
   logic [15:0] dc1_reg;
   logic wr_bmc;
   logic wr_phc;
   logic wr_ldc;
   logic wr_dc1;
   assign wr_bmc = mgmt_req.wr && mgmt_req.addr == pcfg_pkg::ADDR_BASIC_MODE_CONTROL;
   assign wr_phc = mgmt_req.wr && mgmt_req.addr == pcfg_pkg::ADDR_PHY_CONTROL;
   assign wr_ldc = mgmt_req.wr && mgmt_req.addr == pcfg_pkg::ADDR_LED_DIRECT_CONTROL;
   assign wr_dc1 = mgmt_req.wr && mgmt_req.addr == pcfg_pkg::ADDR_DIAG_CONTROL_ONE;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bmc_reg <= pcfg_pkg::BMC_RESET;
         phc_reg <= {11'h000, pcfg_pkg::PHC_ADDR_DEFAULT};
         ldc_reg <= 16'h0000;
         dc1_reg <= 16'h0000;
      end else if (ce) begin
         if (capture) begin
            phc_reg[pcfg_pkg::PHC_ADDR_MSB:pcfg_pkg::PHC_ADDR_LSB] <= strap_s2_reg[4:0];
            phc_reg[pcfg_pkg::PHC_INDICATOR_MODE] <= strap_s2_reg[5];
         end else if (wr_phc) begin
            // a written zero address changes nothing but the field
            phc_reg <= mgmt_req.wdata & pcfg_pkg::PHC_WRITE_MASK;
         end
         if (wr_bmc) begin
            bmc_reg <= mgmt_req.wdata & pcfg_pkg::BMC_WRITE_MASK;
         end
         if (wr_ldc) begin
            ldc_reg <= mgmt_req.wdata & pcfg_pkg::LDC_WRITE_MASK;
         end
         if (wr_dc1) begin
            dc1_reg <= mgmt_req.wdata & pcfg_pkg::DC1_WRITE_MASK;
         end
      end
   end

   // operating mode
   logic isolate;
   logic loopback;
   logic speed100;
   logic full_duplex;
   assign isolate = strap_iso_reg || bmc_reg[pcfg_pkg::BMC_ISOLATE];
   assign loopback = bmc_reg[pcfg_pkg::BMC_LOOPBACK];
   // with autoneg left on during loopback the mode may still move
   assign speed100 = bmc_reg[pcfg_pkg::BMC_AUTONEG_EN] ? an_speed100 :
      bmc_reg[pcfg_pkg::BMC_SPEED100];
   assign full_duplex = bmc_reg[pcfg_pkg::BMC_AUTONEG_EN] ? an_full_duplex :
      bmc_reg[pcfg_pkg::BMC_FULL_DUPLEX];

   // link detection, independent of isolate
   logic [2:0] nlp_cnt_reg;
   logic link10_reg;
   logic link;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nlp_cnt_reg <= 3'h0;
         link10_reg <= 1'b0;
      end else if (ce) begin
         if (media_link_fail) begin
            nlp_cnt_reg <= 3'h0;
            link10_reg <= 1'b0;
         end else if (media_valid_packet) begin
            link10_reg <= 1'b1;
         end else if (media_link_pulse) begin
            if (nlp_cnt_reg == 3'(pcfg_pkg::LINK_PULSES_NEEDED - 1)) begin
               link10_reg <= 1'b1;
            end else begin
               nlp_cnt_reg <= nlp_cnt_reg + 3'h1;
            end
         end
      end
   end
   assign link = speed100 ? media_signal_detect : link10_reg;

   // self-test
   logic st_run;
   logic st_long;
   logic [10:0] pkt_cnt_reg;
   logic st_win;
   logic gen_bit;
   logic st_rx_valid;
   logic st_rx_bit;
   logic chk_bit;
   logic [3:0] fill_reg;
   logic st_pass_reg;
   logic st_err_reg;
   logic [7:0] err_cnt_reg;
   logic miscompare;
   assign st_run = phc_reg[pcfg_pkg::PHC_SELFTEST_START];
   assign st_long = phc_reg[pcfg_pkg::PHC_PRBS_LENGTH];
   assign st_win = st_run && (dc1_reg[pcfg_pkg::DC1_CONTINUOUS] ||
      pkt_cnt_reg < 11'(pcfg_pkg::SELFTEST_PKT_CYCLES));
   assign st_rx_valid = loopback ? st_win : media_rx.rx_dv;
   assign st_rx_bit = loopback ? gen_bit : media_rx.rxd[0];
   assign miscompare = st_run && st_rx_valid &&
      fill_reg == 4'(pcfg_pkg::PRBS_FILL) && st_rx_bit != chk_bit;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pkt_cnt_reg <= 11'h000;
      end else if (ce) begin
         if (!st_run || dc1_reg[pcfg_pkg::DC1_CONTINUOUS] ||
            pkt_cnt_reg == 11'(pcfg_pkg::SELFTEST_PKT_CYCLES + pcfg_pkg::SELFTEST_GAP_CYCLES - 1))
         begin
            pkt_cnt_reg <= 11'h000;
         end else begin
            pkt_cnt_reg <= pkt_cnt_reg + 11'h001;
         end
      end
   end

   pcfg_prbs u_gen (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .step(st_win),
      .long_sel(st_long),
      .feed_ext(1'b0),
      .ext_bit(1'b0),
      .predict(gen_bit)
   );

   pcfg_prbs u_chk (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .step(st_run && st_rx_valid),
      .long_sel(st_long),
      .feed_ext(1'b1),
      .ext_bit(st_rx_bit),
      .predict(chk_bit)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fill_reg <= 4'h0;
         st_pass_reg <= 1'b0;
         st_err_reg <= 1'b0;
         err_cnt_reg <= 8'h00;
      end else if (ce) begin
         if (wr_phc) begin
            // restart clears the latch; a miscompare in the same cycle is dropped
            fill_reg <= 4'h0;
            st_pass_reg <= 1'b0;
            st_err_reg <= 1'b0;
            err_cnt_reg <= 8'h00;
         end else if (st_run && st_rx_valid) begin
            if (fill_reg != 4'(pcfg_pkg::PRBS_FILL)) begin
               fill_reg <= fill_reg + 4'h1;
            end else if (miscompare) begin
               st_err_reg <= 1'b1;
               st_pass_reg <= 1'b0;
               if (err_cnt_reg != 8'hFF) begin
                  err_cnt_reg <= err_cnt_reg + 8'h01;
               end
            end else if (!st_err_reg) begin
               st_pass_reg <= 1'b1;
            end
         end
      end
   end

   // MII side
   logic tx_act;
   logic rx_act;
   logic [2:0] col_cnt_reg;
   logic col_raw;
   pcfg_pkg::pcfg_mii_rx_t rx_src;
   assign tx_act = tx_s2_reg.tx_en && !isolate;
   assign rx_src = loopback ? {tx_act, 1'b0, tx_s2_reg.txd} : media_rx;
   assign rx_act = rx_src.rx_dv;
   assign col_raw = !full_duplex && !loopback && tx_act && media_rx.rx_dv;

   // 10M transmit collisions are held off for seven bit times against noise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         col_cnt_reg <= 3'h0;
      end else if (ce) begin
         if (!col_raw) begin
            col_cnt_reg <= 3'h0;
         end else if (col_cnt_reg != 3'(pcfg_pkg::COL_DELAY_BITS)) begin
            col_cnt_reg <= col_cnt_reg + 3'h1;
         end
      end
   end

   // the clock output only shows the pin is live; it is not a true 2.5/25 MHz rate
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mii_rx <= '0;
         mii_crs <= 1'b0;
         mii_col <= 1'b0;
         mii_clk_o <= 1'b0;
         mii_oe <= 1'b0;
      end else if (ce) begin
         mii_rx <= rx_src;
         mii_crs <= full_duplex ? rx_act : (rx_act || tx_act);
         mii_col <= col_raw && (speed100 || col_cnt_reg == 3'(pcfg_pkg::COL_DELAY_BITS));
         mii_clk_o <= !mii_clk_o;
         mii_oe <= !isolate;
      end
   end

   // media side
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         media_tx <= '0;
         media_idle <= 1'b1;
      end else if (ce) begin
         if (loopback) begin
            media_tx <= '0;
            media_idle <= 1'b1;
         end else if (st_run) begin
            media_tx <= {st_win, 3'h0, gen_bit};
            media_idle <= !st_win;
         end else begin
            media_tx <= tx_act ? tx_s2_reg : '0;
            media_idle <= !tx_act;
         end
      end
   end

   // indicators
   logic [BW-1:0] blink_cnt_reg;
   logic blink_reg;
   logic link_on;
   logic link_val;
   logic rate_val;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blink_cnt_reg <= '0;
         blink_reg <= 1'b0;
      end else if (ce) begin
         if (blink_cnt_reg == BW'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg <= !blink_reg;
         end else begin
            blink_cnt_reg <= blink_cnt_reg + 1'b1;
         end
      end
   end

   always_comb begin
      link_on = phc_reg[pcfg_pkg::PHC_INDICATOR_MODE] ? link :
         (link && !((tx_act || rx_act) && blink_reg));
      link_val = ldc_reg[pcfg_pkg::LDC_LINK_OVERRIDE] ?
         ldc_reg[pcfg_pkg::LDC_LINK_VALUE] : link_on;
      rate_val = ldc_reg[pcfg_pkg::LDC_SPEED_OVERRIDE] ?
         ldc_reg[pcfg_pkg::LDC_SPEED_VALUE] : speed100;
   end

   // pins stay undriven until straps are taken so the strap level is not fought
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link_indicator_o <= 1'b0;
         link_indicator_oe <= 1'b0;
         rate_indicator_o <= 1'b0;
         rate_indicator_oe <= 1'b0;
      end else if (ce) begin
         link_indicator_o <= link_val ^ link_pol_reg;
         rate_indicator_o <= rate_val ^ rate_pol_reg;
         link_indicator_oe <= strapped_reg;
         rate_indicator_oe <= strapped_reg;
      end
   end

   // management answers, isolated or not
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mgmt_ack <= 1'b0;
         mgmt_rdata <= 16'h0000;
      end else if (ce) begin
         mgmt_ack <= mgmt_req.rd || mgmt_req.wr;
         if (!mgmt_req.rd) begin
            mgmt_rdata <= 16'h0000;
         end else if (mgmt_req.addr == pcfg_pkg::ADDR_BASIC_MODE_CONTROL) begin
            mgmt_rdata <= bmc_reg;
         end else if (mgmt_req.addr == pcfg_pkg::ADDR_PHY_STATUS_SUMMARY) begin
            mgmt_rdata <= {12'h000, loopback, full_duplex, !speed100, link};
         end else if (mgmt_req.addr == pcfg_pkg::ADDR_LED_DIRECT_CONTROL) begin
            mgmt_rdata <= ldc_reg;
         end else if (mgmt_req.addr == pcfg_pkg::ADDR_PHY_CONTROL) begin
            mgmt_rdata <= {phc_reg[15:11], st_pass_reg, phc_reg[9:0]};
         end else if (mgmt_req.addr == pcfg_pkg::ADDR_DIAG_CONTROL_ONE) begin
            mgmt_rdata <= {err_cnt_reg, dc1_reg[7:0]};
         end else begin
            mgmt_rdata <= 16'h0000;
         end
      end
   end
endmodule

/* test/pcfg_top_monitor.sv */
module pcfg_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire pcfg_pkg::pcfg_mgmt_req_t mgmt_req,
   input wire logic mgmt_ack,
   input wire logic [15:0] mgmt_rdata,
   input wire logic mii_crs,
   input wire logic mii_col,
   input wire logic mii_oe,
   input wire pcfg_pkg::pcfg_mii_tx_t media_tx,
   input wire logic media_idle,
   input wire logic link_indicator_oe,
   input wire logic rate_indicator_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic [3:0] cnt_reg;
   logic req;
   logic ldc_wr;
   logic ldc_rd;
   assign req = ce && (mgmt_req.rd || mgmt_req.wr);
   assign ldc_wr = req && !mgmt_req.rd && mgmt_req.addr == pcfg_pkg::ADDR_LED_DIRECT_CONTROL;
   assign ldc_rd = req && !mgmt_req.wr && mgmt_req.addr == pcfg_pkg::ADDR_LED_DIRECT_CONTROL;
   // cycles since reset release, saturating so it never wraps back
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 4'h0;
      end else if (ce && cnt_reg != 4'hF) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   a_ack_follows_req: assert property (req |=> mgmt_ack)
      else $error("request not acknowledged");
   a_ack_has_cause: assert property (mgmt_ack |-> $past(req))
      else $error("ack without request");
   a_rdata_quiet: assert property (!mgmt_ack |-> mgmt_rdata == 16'h0000)
      else $error("read data outside ack");
   a_ldc_readback: assert property (ldc_wr ##1 !mgmt_req.wr ##1 ldc_rd |=>
      mgmt_rdata == ($past(mgmt_req.wdata, 3) & pcfg_pkg::LDC_WRITE_MASK))
      else $error("indicator register readback wrong");
   a_isolate_oe: assert property (req && mgmt_req.wr && mgmt_req.addr == 5'h00
      && mgmt_req.wdata[10] |-> ##[1:3] !mii_oe)
      else $error("isolate did not float outputs");
   a_isolate_idle: assert property (!mii_oe |-> media_idle && !media_tx.tx_en)
      else $error("media data while isolated");
   a_col_has_crs: assert property (mii_col |-> mii_crs)
      else $error("collision without carrier");
   a_strap_oe: assert property (cnt_reg == 4'h7 |-> link_indicator_oe && rate_indicator_oe)
      else $error("indicators not driven after strap capture");
endmodule

bind pcfg_top pcfg_chk u_mon (.clk, .nrst, .ce, .mgmt_req, .mgmt_ack, .mgmt_rdata, .mii_crs,
   .mii_col, .mii_oe, .media_tx, .media_idle, .link_indicator_oe, .rate_indicator_oe);

/* test/pcfg_mac_model.sv */
module pcfg_mac_model (
   input wire logic clk,
   input wire logic send,
   output pcfg_pkg::pcfg_mii_tx_t mii_tx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial mii_tx = '0;
   // idle nibble flips each cycle so stale data never looks valid
   always @(posedge clk) begin
      mii_tx.tx_en <= send;
      mii_tx.txd <= send ? mii_tx.txd + 4'h1 : ~mii_tx.txd;
   end
endmodule

/* test/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   pcfg_pkg::pcfg_mgmt_req_t mgmt_req = '0;
   logic mgmt_ack;
   logic [15:0] mgmt_rdata;
   logic [4:0] address_strap = 5'h01;
   logic indicator_mode_select = 1'b1;
   pcfg_pkg::pcfg_mii_tx_t mii_tx;
   pcfg_pkg::pcfg_mii_rx_t mii_rx;
   pcfg_pkg::pcfg_mii_rx_t media_rx = '0;
   pcfg_pkg::pcfg_mii_tx_t media_tx;
   logic mii_crs, mii_col, mii_clk_o, mii_oe, media_idle;
   logic an_speed100 = 1'b0;
   logic an_full_duplex = 1'b1;
   logic media_signal_detect = 1'b0;
   logic [2:0] ev = 3'h0;
   logic send = 1'b0;
   logic link_pull = 1'b0;
   logic lio, lioe, rio, rioe;
   wire logic link_pin = lioe ? lio : link_pull;
   wire logic rate_pin = rioe ? rio : 1'b0;
   int miscompares = 0;
   int n_checks = 0;
   int lows;
   logic [15:0] q;

   always #12.5 clk = ~clk;

   pcfg_top #(.BLINK_CYCLES(4)) u_dut (
      .clk, .nrst, .ce, .mgmt_req, .mgmt_ack, .mgmt_rdata, .address_strap,
      .indicator_mode_select, .mii_tx, .mii_rx, .mii_crs, .mii_col, .mii_clk_o, .mii_oe,
      .an_speed100, .an_full_duplex, .media_signal_detect, .media_link_pulse(ev[0]),
      .media_link_fail(ev[1]), .media_valid_packet(ev[2]), .media_rx, .media_tx,
      .media_idle, .link_indicator_i(link_pin), .link_indicator_o(lio),
      .link_indicator_oe(lioe), .rate_indicator_i(rate_pin), .rate_indicator_o(rio),
      .rate_indicator_oe(rioe)
   );
   pcfg_mac_model u_mac (.clk, .send, .mii_tx);

   task close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task xfer(input logic r, input logic w, input logic [4:0] a, input logic [15:0] d);
      int i;
      @(posedge clk) mgmt_req <= '{r, w, a, d};
      @(posedge clk) mgmt_req <= '0;
      #1;
      for (i = 0; i < 4 && mgmt_ack !== 1'b1; i++) @(posedge clk) #1;
      if (mgmt_ack !== 1'b1) begin
         miscompares++;
         close_out();
      end
      q = mgmt_rdata;
   endtask

   task wr(input logic [4:0] a, input logic [15:0] d);
      xfer(1'b0, 1'b1, a, d);
   endtask

   task rd(input logic [4:0] a);
      xfer(1'b1, 1'b0, a, 16'h0000);
   endtask

   task evp(input logic [2:0] m, input int n);
      repeat (n) begin
         @(posedge clk) ev <= m;
         @(posedge clk) ev <= 3'h0;
      end
      tick(2);
   endtask

   task low_count;
      lows = 0;
      repeat (16) begin
         @(posedge clk) #1;
         if (lio === 1'b0) lows++;
      end
   endtask

   // counts cycles without media transmit over one full packet period
   task gap_count;
      lows = 0;
      repeat (pcfg_pkg::SELFTEST_PKT_CYCLES + pcfg_pkg::SELFTEST_GAP_CYCLES) begin
         @(posedge clk) #1;
         if (media_tx.tx_en !== 1'b1) lows++;
      end
   endtask

   task reset_with(input logic [4:0] s, input logic lp, input logic m);
      @(posedge clk);
      nrst <= 1'b0;
      address_strap <= s;
      link_pull <= lp;
      indicator_mode_select <= m;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick(8);
   endtask

   initial begin
      reset_with(5'h01, 1'b0, 1'b1);
      rd(5'h19); chk(q, 16'h0021);
      rd(5'h05); chk(q, 16'h0000);
      q = 16'(mii_clk_o);
      tick(1); chk(16'(mii_clk_o), q ^ 16'h0001);
      // clock enable low must freeze the toggle
      @(posedge clk) ce <= 1'b0;
      tick(1); q = 16'(mii_clk_o);
      tick(3); chk(16'(mii_clk_o), q);
      @(posedge clk) ce <= 1'b1;
      // autoneg resolved full duplex at reset
      @(posedge clk) send <= 1'b1;
      media_rx <= 6'h20;
      tick(6); chk(16'(mii_col), 16'h0000);
      @(posedge clk) media_rx <= '0;
      tick(4); chk(16'(mii_crs), 16'h0000);
      @(posedge clk) send <= 1'b0;
      wr(5'h00, 16'h0000);
      wr(5'h00, 16'h4000);
      rd(5'h10); chk(q & 16'h0008, 16'h0008);
      @(posedge clk) send <= 1'b1;
      tick(6); chk(16'(mii_rx.rx_dv), 16'h0001);
      chk(16'(mii_rx.rxd), 16'(4'(mii_tx.txd - 4'h3)));
      chk(16'(media_tx.tx_en), 16'h0000);
      chk(16'(mii_crs), 16'h0001);
      @(posedge clk) send <= 1'b0;
      for (int l = 0; l < 2; l++) begin
         wr(5'h19, 16'h0101 | (16'(l) << 11));
         rd(5'h19); chk(q & 16'h0400, 16'h0000);
         tick(60);
         rd(5'h19); chk(q & 16'h0D00, 16'h0500 | (16'(l) << 11));
         rd(5'h1B); chk(q, 16'h0000);
      end
      wr(5'h1B, 16'h0020); rd(5'h1B); chk(q, 16'h0020);
      wr(5'h1B, 16'h0000);
      // a steady ones stream never fits a two-tap sequence; zeros would
      wr(5'h19, 16'h0101);
      wr(5'h00, 16'h0000);
      @(posedge clk) media_rx <= 6'h21;
      tick(40);
      rd(5'h19); chk(q & 16'h0400, 16'h0000);
      rd(5'h1B); chk(16'(q[15:8] != 8'h00), 16'h0001);
      gap_count(); chk(16'(lows != 0), 16'h0001);
      wr(5'h1B, 16'h0020);
      gap_count(); chk(16'(lows), 16'h0000);
      wr(5'h1B, 16'h0000);
      @(posedge clk) media_rx <= '0;
      wr(5'h19, 16'h0000);
      rd(5'h1B); chk(q, 16'h0000);
      tick(3); chk(16'(mii_oe), 16'h0001);
      wr(5'h00, 16'h0400);
      tick(3); chk(16'(mii_oe), 16'h0000);
      chk(16'(media_idle), 16'h0001);
      @(posedge clk) send <= 1'b1;
      tick(4); chk(16'(media_tx.tx_en), 16'h0000);
      evp(3'h1, 6); rd(5'h10); chk(q & 16'h0001, 16'h0000);
      evp(3'h1, 1); rd(5'h10); chk(q & 16'h0001, 16'h0001);
      evp(3'h2, 1); rd(5'h10); chk(q & 16'h0001, 16'h0000);
      evp(3'h4, 1); rd(5'h10); chk(q & 16'h0001, 16'h0001);
      wr(5'h00, 16'h0000);
      tick(3); chk(16'(mii_oe), 16'h0001);
      // half duplex 10M: collision held off seven cycles
      @(posedge clk) media_rx <= 6'h20;
      tick(3); chk(16'(mii_col), 16'h0000);
      chk(16'(mii_crs), 16'h0001);
      tick(8); chk(16'(mii_col), 16'h0001);
      @(posedge clk) media_rx <= '0;
      low_count(); chk(16'(lows != 0), 16'h0001);
      wr(5'h19, 16'h0020);
      low_count(); chk(16'(lows), 16'h0000);
      @(posedge clk) send <= 1'b0;
      wr(5'h18, 16'h0018); rd(5'h18); chk(q, 16'h0018);
      tick(2); chk(16'(lio), 16'h0000);
      wr(5'h18, 16'h0000);
      wr(5'h00, 16'h2000);
      tick(3); chk(16'(rio), 16'h0001);
      wr(5'h00, 16'h0000);
      tick(3); chk(16'(rio), 16'h0000);
      reset_with(5'h00, 1'b1, 1'b0);
      chk(16'(mii_oe), 16'h0000);
      rd(5'h19); chk(q & 16'h003F, 16'h0000);
      chk(16'(lio), 16'h0001);
      chk(16'(lioe), 16'h0001);
      close_out();
   end
endmodule
